// File: hw/sesf_pkg.sv
package sesf_pkg;
   localparam int unsigned BYTE_W = 8;
   localparam int unsigned CLK_HZ = 25000000;
   localparam int unsigned WRITE_CYCLE_MS = 5;
   localparam int unsigned WRITE_CYCLE_CYC = CLK_HZ / 1000 * WRITE_CYCLE_MS;
   // op-code pattern: upper nibble zero, bit 3 ignored
   localparam logic [7:0] OPC_MASK = 8'hF7;
   localparam logic [7:0] OPC_SET_WEL = 8'h06;
   localparam logic [7:0] OPC_CLR_WEL = 8'h04;
   localparam logic [7:0] OPC_RD_STATUS = 8'h05;
   localparam logic [7:0] OPC_WR_STATUS = 8'h01;
   localparam logic [7:0] OPC_RD_ARRAY = 8'h03;
   localparam logic [7:0] OPC_WR_ARRAY = 8'h02;
   localparam int unsigned SR_BUSY = 0;
   localparam int unsigned SR_WEL = 1;
   localparam int unsigned SR_BP_LO = 2;
   localparam int unsigned SR_BP_HI = 3;
   localparam int unsigned SR_PPEN = 7;
   localparam logic [7:0] SR_ALL_ONES = 8'hFF;
   localparam logic [1:0] BP_RESET = 2'h0;
   localparam logic [2:0] BIT_LAST = 3'h7;
   typedef enum logic [2:0] {
      SESF_OP_NONE, SESF_OP_SET_WEL, SESF_OP_CLR_WEL, SESF_OP_RD_STATUS,
      SESF_OP_WR_STATUS, SESF_OP_RD_ARRAY, SESF_OP_WR_ARRAY, SESF_OP_BAD
   } sesf_op_e;
endpackage

// File: hw/sesf_sync_if.sv
`timescale 1ns/10ps
interface sesf_sync_if;
   logic sck;
   logic sck_rise;
   logic sck_fall;
   logic sel_n;
   logic sel_fall;
   logic din;
   logic pause_n;
   logic wp_n;
   modport src (output sck, sck_rise, sck_fall, sel_n, sel_fall, din, pause_n, wp_n);
   modport dst (input sck, sck_rise, sck_fall, sel_n, sel_fall, din, pause_n, wp_n);
endinterface

// File: hw/sesf_pin_sync.sv
`timescale 1ns/10ps
module sesf_pin_sync (
   input wire logic clk,      // system clock
   input wire logic nrst,     // async reset, active low
   input wire logic sck_pin,  // serial clock pin
   input wire logic sel_n_pin, // select pin
   input wire logic din_pin,  // serial data in pin
   input wire logic pause_n_pin, // pause pin
   input wire logic wp_n_pin, // write protect pin
   sesf_sync_if.src sy        // synchronised view
);
   logic [4:0] s1;
   logic [4:0] s2;
   logic sck_d;
   logic sel_d;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s1 <= 5'h1E;
         s2 <= 5'h1E;
         sck_d <= 1'b0;
         sel_d <= 1'b1;
      end else begin
         s1 <= {wp_n_pin, pause_n_pin, sel_n_pin, din_pin, sck_pin};
         s2 <= s1;
         sck_d <= s2[0];
         sel_d <= s2[2];
      end
   end
   assign sy.sck = s2[0];
   assign sy.din = s2[1];
   assign sy.sel_n = s2[2];
   assign sy.pause_n = s2[3];
   assign sy.wp_n = s2[4];
   assign sy.sck_rise = s2[0] & ~sck_d;
   assign sy.sck_fall = ~s2[0] & sck_d;
   assign sy.sel_fall = ~s2[2] & sel_d;
endmodule

// File: hw/sesf_front_end.sv
`timescale 1ns/10ps
module sesf_front_end #(
   parameter int unsigned WRITE_CYC = sesf_pkg::WRITE_CYCLE_CYC // self-timed write length
) (
   input wire logic clk,         // 25 MHz system clock
   input wire logic nrst,        // async reset, active low
   input wire logic sck,         // serial clock from master
   input wire logic sel_n,       // device select, active low
   input wire logic din,         // serial data in
   output logic dout,            // serial data out
   output logic dout_oe_n,       // output enable, low drives dout
   input wire logic pause_n,     // pause, active low
   input wire logic wp_n,        // write protect, active low
   output logic [2:0] op,        // decoded op-code of current frame
   output logic op_valid,        // one-cycle pulse when op-code taken
   output logic busy,            // internal write in progress
   output logic wel,             // write-enable latch
   output logic [1:0] bp,        // block protect bits
   output logic ppen             // protect-pin enable bit
);
   sesf_sync_if sy ();
   sesf_pin_sync u_sync (
      .clk(clk), .nrst(nrst), .sck_pin(sck), .sel_n_pin(sel_n), .din_pin(din),
      .pause_n_pin(pause_n), .wp_n_pin(wp_n), .sy(sy)
   );

   function automatic sesf_pkg::sesf_op_e decode(input logic [7:0] b);
      logic [7:0] m;
      m = b & sesf_pkg::OPC_MASK;
      if (m == sesf_pkg::OPC_SET_WEL) return sesf_pkg::SESF_OP_SET_WEL;
      else if (m == sesf_pkg::OPC_CLR_WEL) return sesf_pkg::SESF_OP_CLR_WEL;
      else if (m == sesf_pkg::OPC_RD_STATUS) return sesf_pkg::SESF_OP_RD_STATUS;
      else if (m == sesf_pkg::OPC_WR_STATUS) return sesf_pkg::SESF_OP_WR_STATUS;
      else if (m == sesf_pkg::OPC_RD_ARRAY) return sesf_pkg::SESF_OP_RD_ARRAY;
      else if (m == sesf_pkg::OPC_WR_ARRAY) return sesf_pkg::SESF_OP_WR_ARRAY;
      else return sesf_pkg::SESF_OP_BAD;
   endfunction

   typedef enum logic [1:0] {SESF_IDLE, SESF_OPCODE, SESF_DATA, SESF_LOCKED} sesf_state_e;
   sesf_state_e state;
   sesf_pkg::sesf_op_e cur_op;
   logic [7:0] shreg;
   logic [7:0] txreg;
   logic [2:0] bitcnt;
   logic paused;
   logic wr_armed;
   logic [7:0] wr_byte;
   logic [31:0] wcnt;
   logic [7:0] status;

   // pause engages and releases only while the serial clock is low, except that deselect releases it at once
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) paused <= 1'b0;
      else if (sy.sel_n) paused <= 1'b0;
      else if (!sy.sck) paused <= ~sy.pause_n;
   end

   logic active;
   assign active = !sy.sel_n && !paused;

   logic [7:0] next_shreg;
   assign next_shreg = {shreg[6:0], sy.din};

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= SESF_IDLE;
         cur_op <= sesf_pkg::SESF_OP_NONE;
         shreg <= '0;
         bitcnt <= '0;
      end else if (sy.sel_n) begin
         state <= SESF_IDLE;
      end else if (sy.sel_fall) begin
         state <= SESF_OPCODE;
         cur_op <= sesf_pkg::SESF_OP_NONE;
         bitcnt <= '0;
      end else if (active && sy.sck_rise && state != SESF_LOCKED) begin
         shreg <= next_shreg;
         bitcnt <= bitcnt + 3'h1;
         if (state == SESF_OPCODE && bitcnt == sesf_pkg::BIT_LAST) begin
            cur_op <= decode(next_shreg);
            state <= (decode(next_shreg) == sesf_pkg::SESF_OP_BAD) ? SESF_LOCKED : SESF_DATA;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         op <= '0;
         op_valid <= 1'b0;
      end else begin
         op_valid <= 1'b0;
         if (active && sy.sck_rise && state == SESF_OPCODE && bitcnt == sesf_pkg::BIT_LAST) begin
            op <= decode(next_shreg);
            op_valid <= 1'b1;
         end
      end
   end

   // status write latched at end of each data byte, committed when select rises
   logic prot;
   assign prot = !sy.wp_n && ppen;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_armed <= 1'b0;
         wr_byte <= '0;
      end else if (sy.sel_fall) begin
         wr_armed <= 1'b0;
      end else if (!sy.sel_n && prot) begin
         wr_armed <= 1'b0;
      end else if (active && sy.sck_rise && state == SESF_DATA && cur_op == sesf_pkg::SESF_OP_WR_STATUS
                   && bitcnt == sesf_pkg::BIT_LAST && wel && !busy) begin
         wr_armed <= 1'b1;
         wr_byte <= next_shreg;
      end else if (sy.sel_n) begin
         wr_armed <= 1'b0;
      end
   end

   logic start_wr;
   assign start_wr = wr_armed && sy.sel_n && !prot;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         busy <= 1'b0;
         wcnt <= '0;
      end else if (start_wr) begin
         busy <= 1'b1;
         wcnt <= WRITE_CYC - 1;
      end else if (busy) begin
         if (wcnt == '0) busy <= 1'b0;
         else wcnt <= wcnt - 32'h1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bp <= sesf_pkg::BP_RESET;
         ppen <= 1'b0;
      end else if (start_wr) begin
         bp <= wr_byte[sesf_pkg::SR_BP_HI:sesf_pkg::SR_BP_LO];
         ppen <= wr_byte[sesf_pkg::SR_PPEN] | (ppen & !sy.wp_n);
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) wel <= 1'b0;
      else if (busy && wcnt == '0) wel <= 1'b0;
      else if (sy.sel_n && state == SESF_DATA && !busy) begin
         if (cur_op == sesf_pkg::SESF_OP_SET_WEL) wel <= 1'b1;
         else if (cur_op == sesf_pkg::SESF_OP_CLR_WEL) wel <= 1'b0;
      end
   end

   always_comb begin
      status = '0;
      status[sesf_pkg::SR_BUSY] = busy;
      status[sesf_pkg::SR_WEL] = wel;
      status[sesf_pkg::SR_BP_HI:sesf_pkg::SR_BP_LO] = bp;
      status[sesf_pkg::SR_PPEN] = ppen;
      if (busy) status = sesf_pkg::SR_ALL_ONES;
   end

   // output shifts on falling clock, status repeats while read continues
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         txreg <= '0;
         dout <= 1'b0;
         dout_oe_n <= 1'b1;
      end else begin
         dout_oe_n <= !(active && state == SESF_DATA && cur_op == sesf_pkg::SESF_OP_RD_STATUS);
         if (active && sy.sck_fall && state == SESF_DATA && cur_op == sesf_pkg::SESF_OP_RD_STATUS) begin
            if (bitcnt == '0) begin
               dout <= status[7];
               txreg <= {status[6:0], 1'b0};
            end else begin
               dout <= txreg[7];
               txreg <= {txreg[6:0], 1'b0};
            end
         end
      end
   end

   chk_locked_quiet: assert property (@(posedge clk) disable iff (!nrst)
      state == SESF_LOCKED |-> dout_oe_n) else $error("output driven after bad op-code");
   chk_desel_quiet: assert property (@(posedge clk) disable iff (!nrst)
      $past(sy.sel_n) |-> dout_oe_n) else $error("output driven while deselected");
   chk_pause_quiet: assert property (@(posedge clk) disable iff (!nrst)
      $past(paused) |-> dout_oe_n) else $error("output driven while paused");
   chk_pause_shift: assert property (@(posedge clk) disable iff (!nrst)
      paused |=> $stable(shreg)) else $error("input shifted while paused");
   chk_prot_block: assert property (@(posedge clk) disable iff (!nrst)
      !sy.sel_n && prot |=> !wr_armed) else $error("status write armed while protected");
   chk_busy_hold: assert property (@(posedge clk) disable iff (!nrst)
      $rose(busy) |-> busy [*8]) else $error("busy dropped early");
   chk_ppen_keep: assert property (@(posedge clk) disable iff (!nrst)
      ppen && !sy.wp_n && !busy |=> ppen) else $error("enable bit cleared under protection");
   chk_opcode_take: assert property (@(posedge clk) disable iff (!nrst)
      op_valid |-> $past(state) == SESF_OPCODE) else $error("op-code taken outside first byte");
endmodule

// File: bench/sesf_master.sv
`timescale 1ns/10ps
module sesf_master (
   input wire logic clk, // system clock
   input wire logic dout, // serial data from device
   output logic sck, // serial clock, still low between frames
   output logic sel_n, // device select, active low
   output logic din, // serial data to device
   output logic pause_n, // pause, active low
   output logic wp_n // write protect, active low
);
   initial begin
      sck = 1'b0;
      sel_n = 1'b1;
      din = 1'b0;
      pause_n = 1'b1;
      wp_n = 1'b1;
   end
   // released data line toggles so a stale bit never looks valid
   always @(posedge clk) begin
      if (sel_n || !pause_n) din <= ~din;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   // pz: bit index at which a pause is inserted, -1 for none
   task automatic frame(input logic [15:0] tx, input int nb, input int pz, input logic wp_end,
         output logic [15:0] rx);
      rx = 16'h0000;
      sel_n <= 1'b0;
      wt(4);
      for (int i = nb * 8 - 1; i >= 0; i--) begin
         if (i == pz) begin
            pause_n <= 1'b0;
            repeat (3) begin
               wt(4);
               sck <= 1'b1;
               wt(4);
               sck <= 1'b0;
            end
            wt(4);
            pause_n <= 1'b1;
            wt(4);
         end
         din <= tx[i];
         wt(4);
         sck <= 1'b1;
         wt(4);
         rx[i] = dout;
         sck <= 1'b0;
      end
      wt(4);
      wp_n <= wp_end;
      wt(4);
      sel_n <= 1'b1;
      wt(8);
   endtask
endmodule

// File: bench/serial_eeprom_spi_slave_front_end_test.sv
`timescale 1ns/10ps
module serial_eeprom_spi_slave_front_end_test;
   logic clk, nrst, sck, sel_n, din, dout, dout_oe_n, pause_n, wp_n, op_valid, busy, wel, ppen;
   logic [2:0] op, last_op;
   logic [1:0] bp;
   logic [15:0] rxd;
   int num_errors = 0, check_count = 0, opv_cnt = 0, oe_cnt = 0, n0, k;
   // row: op-code byte, decoded op, write latch after the frame
   logic [11:0] rows [14] = '{12'h063, 12'h044, 12'h0E3, 12'h0C4, 12'h056, 12'h0D6, 12'h03A,
      12'h0BA, 12'h02C, 12'h0AC, 12'h018, 12'h098, 12'h10E, 12'h86E};
   sesf_front_end #(.WRITE_CYC(400)) dut (.clk(clk), .nrst(nrst), .sck(sck), .sel_n(sel_n), .din(din),
      .dout(dout), .dout_oe_n(dout_oe_n), .pause_n(pause_n), .wp_n(wp_n), .op(op), .op_valid(op_valid),
      .busy(busy), .wel(wel), .bp(bp), .ppen(ppen));
   sesf_master mst (.clk(clk), .dout(dout), .sck(sck), .sel_n(sel_n), .din(din), .pause_n(pause_n),
      .wp_n(wp_n));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      if (op_valid === 1'b1) begin
         opv_cnt++;
         last_op = op;
      end
      if (dout_oe_n === 1'b0) oe_cnt++;
   end
   task automatic complete_run();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic fr(input logic [15:0] tx, input int nb, input int pz, input logic we);
      mst.frame(tx, nb, pz, we, rxd);
   endtask
   task automatic wr_sr(input logic [7:0] d, input logic w1, input logic w2);
      fr(16'h0006, 1, -1, w1);
      fr({8'h01, d}, 2, -1, w2);
   endtask
   task automatic wait_busy();
      for (n0 = 0; n0 < 600 && busy !== 1'b0; n0++) @(posedge clk);
      if (n0 == 600) begin
         num_errors++;
         $display("CHECK FAILED busy wait expected 0 seen 1");
         complete_run();
      end
   endtask
   function automatic logic [7:0] stat();
      return {ppen, 3'h0, bp, 1'b0, busy};
   endfunction
   initial begin
      nrst = 1'b0;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      chk("oe_n", 8'h01, 8'(dout_oe_n));
      chk("status", 8'h00, {ppen, 3'h0, bp, wel, busy});
      chk("dout", 8'h00, 8'(dout));
      for (k = 0; k < 14; k++) begin
         n0 = opv_cnt;
         fr({8'h00, rows[k][11:4]}, 1, -1, 1'b1);
         chk("op", 8'(rows[k][3:1]), 8'(last_op));
         chk("wel", 8'(rows[k][0]), 8'(wel));
         chk("op count", 8'(n0 + 1), 8'(opv_cnt));
      end
      fr(16'h0006, 1, -1, 1'b1);
      fr(16'h0500, 2, -1, 1'b1);
      chk("rd status", 8'h02, rxd[7:0]);
      wr_sr(8'h8C, 1'b1, 1'b1);
      chk("busy", 8'h01, 8'(busy));
      fr(16'h0500, 2, -1, 1'b1);
      chk("rd busy", 8'hFF, rxd[7:0]);
      chk("busy", 8'h01, 8'(busy));
      wait_busy();
      chk("status", 8'h8C, stat());
      wr_sr(8'h00, 1'b0, 1'b0);
      chk("busy", 8'h00, 8'(busy));
      chk("status", 8'h8C, stat());
      wr_sr(8'h00, 1'b1, 1'b0);
      chk("busy", 8'h00, 8'(busy));
      chk("status", 8'h8C, stat());
      wr_sr(8'h00, 1'b1, 1'b1);
      fr(16'h0500, 2, -1, 1'b0);
      wait_busy();
      chk("status", 8'h00, stat());
      wr_sr(8'h0C, 1'b0, 1'b0);
      chk("busy", 8'h01, 8'(busy));
      wait_busy();
      chk("status", 8'h0C, stat());
      n0 = opv_cnt;
      k = oe_cnt;
      fr(16'h1005, 2, -1, 1'b0);
      chk("op count", 8'h01, 8'(opv_cnt - n0));
      chk("oe low", 8'h00, 8'(oe_cnt - k));
      fr(16'h0500, 2, 11, 1'b0);
      chk("op", 8'h03, 8'(last_op));
      chk("rd status", 8'h0C, rxd[7:0]);
      complete_run();
   end
endmodule
